// ==== verilog/hlt_timer.sv ====
// hardware-limit period timer with apb register access
`timescale 1ns/1ps
module hlt_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_reset_signal,
   output logic [7:0] count_value,
   output logic period_match,
   output logic postscaled,
   output logic timer_irq
);
   hlt_pkg::hlt_state_t r;
   hlt_pkg::hlt_state_t next_r;

   function automatic logic [6:0] pre_limit(input logic [2:0] sel);
      pre_limit = 7'((8'h01 << sel) - 8'h01);
   endfunction : pre_limit

   logic wr;
   logic rd;
   logic tick;
   logic match;
   logic rise;
   logic fall;
   logic ers;
   logic gate;
   logic hold;
   logic edge_rst;
   logic start_edge;
   logic oneshot;
   logic mono;
   logic reserved;
   logic start_hit;
   logic [4:0] m;

   assign wr = psel && penable && pwrite;
   // read data captured in setup so it stands through the access edge
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = r.prdata;
   assign count_value = r.count_value;
   assign period_match = r.match_d;
   assign postscaled = r.postscaled;
   assign timer_irq = r.irq_flag && r.period_irq_enable;

   always_comb begin
      next_r = r;
      m = r.mode;
      ers = r.ers_s2;
      rise = ers && !r.ers_d;
      fall = !ers && r.ers_d;
      tick = r.prescale_cnt == pre_limit(r.prescale_select);
      match = r.count_value == r.period_shadow;
      gate = 1'b1;
      hold = 1'b0;
      edge_rst = 1'b0;
      start_edge = 1'b0;
      oneshot = m[4:3] == 2'b01 || m == hlt_pkg::HLT_OSL_LOW ||
         m == hlt_pkg::HLT_OSL_HIGH;
      mono = m == hlt_pkg::HLT_MS_RISE || m == hlt_pkg::HLT_MS_FALL ||
         m == hlt_pkg::HLT_MS_ANY;
      reserved = !(m[4:3] == 2'b00 || m[4:3] == 2'b01 || mono ||
         m == hlt_pkg::HLT_OSL_LOW || m == hlt_pkg::HLT_OSL_HIGH);
      next_r.ers_s1 = ext_reset_signal;
      next_r.ers_s2 = r.ers_s1;
      next_r.ers_d = r.ers_s2;
      next_r.postscaled = 1'b0;
      // mode decode of gating, holds, resets and starts
      case (m)
         hlt_pkg::HLT_GATE_HI: gate = ers;
         hlt_pkg::HLT_GATE_LO: gate = !ers;
         hlt_pkg::HLT_RST_ANY: edge_rst = rise || fall;
         hlt_pkg::HLT_RST_RISE: edge_rst = rise;
         hlt_pkg::HLT_RST_FALL: edge_rst = fall;
         hlt_pkg::HLT_RST_LOW: hold = r.on && !ers;
         hlt_pkg::HLT_RST_HIGH: hold = r.on && ers;
         hlt_pkg::HLT_OS_RISE, hlt_pkg::HLT_MS_RISE: start_edge = rise;
         hlt_pkg::HLT_OS_FALL, hlt_pkg::HLT_MS_FALL: start_edge = fall;
         hlt_pkg::HLT_OS_ANY, hlt_pkg::HLT_MS_ANY:
            start_edge = rise || fall;
         hlt_pkg::HLT_OS_HL_RISE: begin
            start_edge = rise;
            edge_rst = rise && r.run == hlt_pkg::HLT_RUN;
         end
         hlt_pkg::HLT_OS_HL_FALL: begin
            start_edge = fall;
            edge_rst = fall && r.run == hlt_pkg::HLT_RUN;
         end
         hlt_pkg::HLT_OS_LV_LOW: begin
            hold = !ers;
            start_edge = rise;
         end
         hlt_pkg::HLT_OS_LV_HIGH: begin
            hold = ers;
            start_edge = fall;
         end
         hlt_pkg::HLT_OSL_LOW: hold = !ers;
         hlt_pkg::HLT_OSL_HIGH: hold = ers;
         default: gate = !reserved;
      endcase
      // idle to run: software start, level release or qualifying edge
      start_hit = 1'b0;
      if (m == hlt_pkg::HLT_SW_GATE || m[4:3] == 2'b00 ||
         m == hlt_pkg::HLT_OS_SW || m == hlt_pkg::HLT_OSL_LOW ||
         m == hlt_pkg::HLT_OSL_HIGH) begin
         start_hit = 1'b1;
      end else begin
         start_hit = start_edge;
      end
      if (!r.on) begin
         // off: counters and state reset, count kept for resume
         next_r.prescale_cnt = 7'h00;
         next_r.post_cnt = 4'h0;
         next_r.hold_cnt = 2'h0;
         // edge modes re-arm; software one-shot resumes where paused
         if (m != hlt_pkg::HLT_OS_SW) begin
            next_r.run = hlt_pkg::HLT_IDLE;
         end
      end else begin
         next_r.prescale_cnt = tick ? 7'h00 : 7'(r.prescale_cnt + 7'h01);
         case (r.run)
            hlt_pkg::HLT_IDLE: begin
               if (start_hit && !reserved && !hold) begin
                  next_r.run = hlt_pkg::HLT_RUN;
               end
            end
            hlt_pkg::HLT_RUN: begin
               if (hold || edge_rst) begin
                  // filtered: the level needs two clocks before it acts
                  if (edge_rst || r.hold_cnt == hlt_pkg::RESTART_DELAY) begin
                     next_r.count_value = hlt_pkg::COUNT_RESET;
                     next_r.period_shadow = r.period_value;
                     next_r.prescale_cnt = 7'h00;
                     next_r.post_cnt = 4'h0;
                     next_r.hold_cnt = edge_rst ? 2'h0 :
                        hlt_pkg::RESTART_DELAY;
                  end else begin
                     next_r.hold_cnt = 2'(r.hold_cnt + 2'h1);
                  end
               end else if (r.hold_cnt != 2'h0 &&
                  r.count_value == hlt_pkg::COUNT_RESET) begin
                  next_r.hold_cnt = 2'(r.hold_cnt - 2'h1);
               end else if (tick && gate) begin
                  next_r.hold_cnt = 2'h0;
                  // tick that sees the match clears, so any prescale works
                  if (match) begin
                     next_r.count_value = hlt_pkg::COUNT_RESET;
                     if (oneshot) begin
                        next_r.on = 1'b0;
                        next_r.run = hlt_pkg::HLT_DONE;
                     end else if (mono) begin
                        next_r.run = hlt_pkg::HLT_IDLE;
                     end
                     next_r.period_shadow = r.period_value;
                     // postscaler counts matches; pulse at ratio
                     if (r.post_cnt == r.postscale_select) begin
                        next_r.post_cnt = 4'h0;
                        next_r.postscaled = 1'b1;
                        next_r.irq_flag = 1'b1;
                     end else begin
                        next_r.post_cnt = 4'(r.post_cnt + 4'h1);
                     end
                  end else begin
                     next_r.count_value = 8'(r.count_value + 8'h01);
                  end
               end
            end
            default: begin
               // done: waits for software to cycle on
               next_r.count_value = hlt_pkg::COUNT_RESET;
            end
         endcase
      end
      next_r.match_d = r.run == hlt_pkg::HLT_RUN && match && tick && gate &&
         !hold && !edge_rst;
      // register writes take effect in the access phase
      if (wr) begin
         if (paddr == hlt_pkg::ADDR_CONTROL) begin
            next_r.on = pwdata[hlt_pkg::CTRL_ON_BIT];
            next_r.prescale_select = pwdata[hlt_pkg::CTRL_PRE_LSB +: 3];
            next_r.postscale_select = pwdata[hlt_pkg::CTRL_POST_LSB +: 4];
            next_r.period_irq_enable = pwdata[hlt_pkg::CTRL_IEN_BIT];
            next_r.period_shadow = r.period_value;
            next_r.prescale_cnt = 7'h00;
            next_r.post_cnt = 4'h0;
            if (pwdata[hlt_pkg::CTRL_ON_BIT] && !r.on &&
               r.run == hlt_pkg::HLT_DONE) begin
               next_r.run = hlt_pkg::HLT_IDLE;
            end
         end else if (paddr == hlt_pkg::ADDR_MODE) begin
            next_r.mode = pwdata[4:0];
         end else if (paddr == hlt_pkg::ADDR_PERIOD) begin
            next_r.period_value = pwdata[7:0];
         end else if (paddr == hlt_pkg::ADDR_COUNT) begin
            next_r.count_value = pwdata[7:0];
            next_r.period_shadow = r.period_value;
            next_r.prescale_cnt = 7'h00;
            next_r.post_cnt = 4'h0;
         end else if (paddr == hlt_pkg::ADDR_STATUS) begin
            // write one to clear; a same-cycle event wins
            if (pwdata[0] && !next_r.postscaled) begin
               next_r.irq_flag = 1'b0;
            end
         end
      end
      if (rd) begin
         if (paddr == hlt_pkg::ADDR_CONTROL) begin
            next_r.prdata = {23'h0, r.period_irq_enable, r.on,
               r.prescale_select, r.postscale_select};
         end else if (paddr == hlt_pkg::ADDR_MODE) begin
            next_r.prdata = {27'h0, r.mode};
         end else if (paddr == hlt_pkg::ADDR_PERIOD) begin
            next_r.prdata = {24'h0, r.period_value};
         end else if (paddr == hlt_pkg::ADDR_COUNT) begin
            next_r.prdata = {24'h0, r.count_value};
         end else if (paddr == hlt_pkg::ADDR_STATUS) begin
            next_r.prdata = {29'h0, r.run};
            next_r.prdata[3] = r.irq_flag;
         end else begin
            next_r.prdata = 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{on: 1'b0, prescale_select: 3'h0, postscale_select: 4'h0,
            period_irq_enable: 1'b0, mode: hlt_pkg::MODE_RESET,
            period_value: hlt_pkg::PERIOD_RESET,
            period_shadow: hlt_pkg::PERIOD_RESET,
            count_value: hlt_pkg::COUNT_RESET, prescale_cnt: 7'h00,
            post_cnt: 4'h0, postscaled: 1'b0, irq_flag: 1'b0,
            hold_cnt: 2'h0, match_d: 1'b0, ers_s1: 1'b0, ers_s2: 1'b0,
            ers_d: 1'b0, run: hlt_pkg::HLT_IDLE, prdata: 32'h0};
      end else begin
         r <= next_r;
      end
   end
endmodule : hlt_timer

// ==== verilog/hlt_pkg.sv ====
// package: register map, field layout and constants of the period timer
package hlt_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // control register fields
   localparam int CTRL_ON_BIT = 7;
   localparam int CTRL_PRE_LSB = 4;
   localparam int CTRL_POST_LSB = 0;
   localparam int CTRL_IEN_BIT = 8;
   // reset values
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [4:0] MODE_RESET = 5'h00;
   // restart delay after an external level reset, in timer clocks
   localparam logic [1:0] RESTART_DELAY = 2'h2;

   typedef enum logic [4:0] {
      HLT_SW_GATE = 5'h00, HLT_GATE_HI = 5'h01, HLT_GATE_LO = 5'h02,
      HLT_RST_ANY = 5'h03, HLT_RST_RISE = 5'h04, HLT_RST_FALL = 5'h05,
      HLT_RST_LOW = 5'h06, HLT_RST_HIGH = 5'h07,
      HLT_OS_SW = 5'h08, HLT_OS_RISE = 5'h09, HLT_OS_FALL = 5'h0a,
      HLT_OS_ANY = 5'h0b, HLT_OS_HL_RISE = 5'h0c, HLT_OS_HL_FALL = 5'h0d,
      HLT_OS_LV_LOW = 5'h0e, HLT_OS_LV_HIGH = 5'h0f,
      HLT_MS_RISE = 5'h11, HLT_MS_FALL = 5'h12, HLT_MS_ANY = 5'h13,
      HLT_OSL_LOW = 5'h16, HLT_OSL_HIGH = 5'h17
   } hlt_mode_t;

   // run state, one-hot
   typedef enum logic [2:0] {
      HLT_IDLE = 3'b001,
      HLT_RUN = 3'b010,
      HLT_DONE = 3'b100
   } hlt_run_t;

   typedef struct packed {
      logic on;
      logic [2:0] prescale_select;
      logic [3:0] postscale_select;
      logic period_irq_enable;
      logic [4:0] mode;
      logic [7:0] period_value;
      logic [7:0] period_shadow;
      logic [7:0] count_value;
      logic [6:0] prescale_cnt;
      logic [3:0] post_cnt;
      logic postscaled;
      logic irq_flag;
      logic [1:0] hold_cnt;
      logic match_d;
      logic ers_s1;
      logic ers_s2;
      logic ers_d;
      hlt_run_t run;
      logic [31:0] prdata;
   } hlt_state_t;
endpackage : hlt_pkg

// ==== sim/hlt_timer_props.sv ====
// checker: port-level properties of the period timer
`timescale 1ns/1ps
module hlt_timer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_reset_signal,
   input wire logic [7:0] count_value,
   input wire logic period_match,
   input wire logic postscaled,
   input wire logic timer_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic irq_wr;
   assign acc = psel && penable;
   // irq output may lag the clearing write by a register stage
   assign irq_wr = acc && pwrite && (paddr == hlt_pkg::ADDR_STATUS ||
      paddr == hlt_pkg::ADDR_CONTROL);
   property p_ready;
      pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_noerr;
      !pslverr;
   endproperty
   a_noerr: assert property (p_noerr) else $error("pslverr high");
   property p_step;
      $changed(count_value) &&
      !$past(acc && pwrite && paddr == hlt_pkg::ADDR_COUNT) |->
      count_value == $past(count_value) + 8'h01 || count_value == 8'h00;
   endproperty
   a_step: assert property (p_step) else $error("count jumped");
   property p_match_pulse;
      period_match |=> !period_match;
   endproperty
   a_match_pulse: assert property (p_match_pulse)
      else $error("match longer than one clock");
   property p_post;
      postscaled |-> period_match || $past(period_match) ||
      $past(period_match, 2);
   endproperty
   a_post: assert property (p_post) else $error("postscale without match");
   property p_reset;
      $rose(presetn) |-> count_value == 8'h00 && !timer_irq;
   endproperty
   a_reset: assert property (p_reset) else $error("state after reset");
   property p_irq_fall;
      $fell(timer_irq) |-> $past(irq_wr) || $past(irq_wr, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
   property p_unmapped;
      acc && !pwrite && paddr > hlt_pkg::ADDR_STATUS |=> prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : hlt_timer_chk
bind hlt_timer hlt_timer_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_reset_signal(ext_reset_signal), .count_value(count_value),
   .period_match(period_match), .postscaled(postscaled),
   .timer_irq(timer_irq));

// ==== sim/hlt_trig_src.sv ====
// partner: on-chip trigger source feeding the timer
`timescale 1ns/1ps
module hlt_trig_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic want,
   output logic ext_reset_signal
);
   logic [2:0] gap;
   // a requested level waits until six clocks have passed since the last
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_reset_signal <= 1'b0;
         gap <= 3'h0;
      end else if (gap != 3'h0) begin
         gap <= gap - 3'h1;
      end else if (want != ext_reset_signal) begin
         ext_reset_signal <= want;
         gap <= 3'h6;
      end
   end
endmodule : hlt_trig_src

// ==== sim/test_hw_limit_period_timer.sv ====
// testbench: apb-driven scenarios for the period timer
`timescale 1ns/1ps
module test_hw_limit_period_timer;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic want = 1'b0;
   logic [31:0] prdata, r;
   logic pready, pslverr, ext_reset_signal, period_match, postscaled, timer_irq;
   logic [7:0] count_value, top, c;
   int error_cnt = 0;
   int total_checks = 0;
   int m;
   always #20 pclk = ~pclk;
   hlt_timer i_hlt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_reset_signal(ext_reset_signal), .count_value(count_value),
      .period_match(period_match), .postscaled(postscaled),
      .timer_irq(timer_irq));
   hlt_trig_src i_hlt_trig_src (.pclk(pclk), .presetn(presetn), .want(want),
      .ext_reset_signal(ext_reset_signal));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50) error_cnt++;
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   // read data is captured in setup and taken at the access edge
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic run(input int n);
      top = 8'h00;
      m = 0;
      repeat (n) begin
         @(posedge pclk);
         if (count_value > top) top = count_value;
         if (period_match === 1'b1) m++;
      end
   endtask : run
   task automatic t_reset();
      rd(hlt_pkg::ADDR_PERIOD);
      chk(r, 32'hff);
      rd(hlt_pkg::ADDR_COUNT);
      chk(r, 32'h0);
      rd(8'h20);
      chk(r, 32'h0);
   endtask : t_reset
   task automatic t_gate();
      wr(hlt_pkg::ADDR_MODE, 32'h00);
      wr(hlt_pkg::ADDR_PERIOD, 32'h05);
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      run(40);
      chk({24'h0, top}, 32'h05);
      chk(32'(m > 4), 32'h1);
      wr(hlt_pkg::ADDR_CONTROL, 32'h00);
      run(1);
      c = count_value;
      run(6);
      chk({24'h0, count_value}, {24'h0, c});
   endtask : t_gate
   task automatic t_oneshot();
      wr(hlt_pkg::ADDR_MODE, 32'h08);
      wr(hlt_pkg::ADDR_PERIOD, 32'h04);
      wr(hlt_pkg::ADDR_COUNT, 32'h00);
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      run(20);
      rd(hlt_pkg::ADDR_CONTROL);
      chk({31'h0, r[7]}, 32'h0);
      chk({24'h0, count_value}, 32'h0);
   endtask : t_oneshot
   task automatic t_mono();
      wr(hlt_pkg::ADDR_MODE, 32'h11);
      wr(hlt_pkg::ADDR_PERIOD, 32'h03);
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      run(10);
      chk({24'h0, top}, 32'h0);
      want <= 1'b1;
      run(30);
      chk({24'h0, top}, 32'h03);
      rd(hlt_pkg::ADDR_CONTROL);
      chk({31'h0, r[7]}, 32'h1);
      chk({24'h0, count_value}, 32'h0);
      wr(hlt_pkg::ADDR_CONTROL, 32'h00);
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      run(12);
      chk({24'h0, top}, 32'h0);
   endtask : t_mono
   task automatic t_level();
      wr(hlt_pkg::ADDR_CONTROL, 32'h00);
      wr(hlt_pkg::ADDR_MODE, 32'h07);
      wr(hlt_pkg::ADDR_PERIOD, 32'hff);
      want <= 1'b0;
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      run(20);
      chk({31'h0, count_value !== 8'h00}, 32'h1);
      want <= 1'b1;
      run(15);
      chk({24'h0, count_value}, 32'h0);
      run(5);
      chk({24'h0, top}, 32'h0);
      want <= 1'b0;
      run(15);
      wr(hlt_pkg::ADDR_CONTROL, 32'h00);
      run(1);
      c = count_value;
      want <= 1'b1;
      run(15);
      chk({24'h0, count_value}, {24'h0, c});
   endtask : t_level
   task automatic t_irq();
      wr(hlt_pkg::ADDR_MODE, 32'h00);
      wr(hlt_pkg::ADDR_PERIOD, 32'h02);
      wr(hlt_pkg::ADDR_COUNT, 32'h00);
      wr(hlt_pkg::ADDR_CONTROL, 32'h181);
      m = 0;
      for (int n = 0; n < 100 && postscaled !== 1'b1; n++) begin
         @(posedge pclk);
         if (period_match === 1'b1) m++;
      end
      chk(32'(m), 32'h2);
      run(4);
      chk({31'h0, timer_irq}, 32'h1);
      wr(hlt_pkg::ADDR_CONTROL, 32'h81);
      run(3);
      chk({31'h0, timer_irq}, 32'h0);
      rd(hlt_pkg::ADDR_STATUS);
      chk({31'h0, r[3]}, 32'h1);
   endtask : t_irq
   task automatic t_resv();
      wr(hlt_pkg::ADDR_CONTROL, 32'h00);
      wr(hlt_pkg::ADDR_MODE, 32'h14);
      wr(hlt_pkg::ADDR_COUNT, 32'h00);
      wr(hlt_pkg::ADDR_CONTROL, 32'h80);
      want <= 1'b0;
      run(20);
      chk({24'h0, top}, 32'h0);
   endtask : t_resv
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gate();
      t_oneshot();
      t_mono();
      t_level();
      t_irq();
      t_resv();
      finish_test();
   end
   // whole run needs well under two thousand clocks
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      finish_test();
   end
endmodule : test_hw_limit_period_timer
